/* File: common/hdm_pkg.sv */
// package: constants and types of the host/processor mailbox control block
// Function
// R01: eight semaphores at consecutive I/O addresses, bit0
// R02: window base 0338, control register 0339
// R03: window base write-only; control readable and writable
// R04: compare base with host A12-A19 per memory cycle
// R05: window on 4K boundaries, lowest 1M only
// R06: window_enable gates every shared-memory host select
// R07: low nibble host-owned, high nibble processor-owned
// R08: host resets clear the low nibble
// R09: processor resets clear the high nibble
// R10: host_to_dsp_irq drives external interrupt zero
// R11: dsp_irq_enable low blocks host-to-processor interrupt
// R12: dsp_to_host_irq raises the host interrupt
// R13: host_irq_enable low blocks processor-to-host interrupt
// R14: board_soft_reset low holds processor board reset
// R15: bank select picks half of expansion SRAM
// R16: boot_map_swap exchanges EPROM and primary SRAM ranges
// R17: semaphores never gate shared-memory accesses
// R18: processor shared-memory data only low eight bits
// R19: host_to_dsp_irq bit0, host_irq_enable bit1
// R20: semaphore granted only when other side free
package hdm_pkg;

  // ********************************************************************
  // host I/O map
  // ********************************************************************
  localparam logic [15:0] HDM_SEM_BASE_ADDR  = 16'h0330; // first semaphore
  localparam logic [15:0] HDM_SEM_LAST_ADDR  = 16'h0337; // last semaphore
  localparam logic [15:0] HDM_WIN_BASE_ADDR  = 16'h0338; // window base, write-only
  localparam logic [15:0] HDM_CTRL_ADDR      = 16'h0339; // shared control register
  localparam int          HDM_SEM_COUNT      = 8;        // number of semaphores
  localparam logic [7:0]  HDM_UNREAD_VALUE   = 8'h00;    // read of a write-only or empty slot

  // ********************************************************************
  // host memory window
  // ********************************************************************
  localparam int          HDM_WIN_LSB        = 12;       // 4K-byte granularity
  localparam int          HDM_WIN_MSB        = 19;       // top of the 1M-byte space
  localparam logic [7:0]  HDM_WIN_BASE_RST   = 8'h00;    // window base after reset

  // ********************************************************************
  // control register layout and reset
  // ********************************************************************
  localparam int          HDM_BIT_H2D_IRQ    = 0;        // host_to_dsp_irq
  localparam int          HDM_BIT_HIRQ_EN    = 1;        // host_irq_enable
  localparam int          HDM_BIT_WIN_EN     = 2;        // window_enable
  localparam int          HDM_BIT_SOFT_RST   = 3;        // board_soft_reset
  localparam int          HDM_BIT_D2H_IRQ    = 4;        // dsp_to_host_irq
  localparam int          HDM_BIT_DIRQ_EN    = 5;        // dsp_irq_enable
  localparam int          HDM_BIT_BANK_SEL   = 6;        // exp_sram_bank_sel
  localparam int          HDM_BIT_BOOT_SWAP  = 7;        // boot_map_swap
  localparam logic [3:0]  HDM_NIBBLE_RST     = 4'h0;     // both nibbles clear on reset

  // ********************************************************************
  // processor address map
  // ********************************************************************
  localparam logic [23:0] HDM_LOW_BASE       = 24'h000000; // low boot range
  localparam logic [23:0] HDM_LOW_LAST       = 24'h003fff;
  localparam logic [23:0] HDM_HIGH_BASE      = 24'hf00000; // high range
  localparam logic [23:0] HDM_HIGH_LAST      = 24'hf03fff;
  localparam int          HDM_EXP_BANK_BITS  = 13;       // 8K-word bank
  localparam int          HDM_SHM_BYTE_BITS  = 8;        // valid processor lane
  localparam logic [23:0] HDM_SHM_UPPER_FILL = 24'h000000; // upper lanes on read

  // control register as a packed carrier, bit 7 first
  typedef struct packed {
    logic bootMapSwap;    // bit 7
    logic expSramBankSel; // bit 6
    logic dspIrqEnable;   // bit 5
    logic dspToHostIrq;   // bit 4
    logic boardSoftReset; // bit 3
    logic windowEnable;   // bit 2
    logic hostIrqEnable;  // bit 1
    logic hostToDspIrq;   // bit 0
  } hdm_ctrl_type;

  // one host bus request
  typedef struct packed {
    logic [19:0] addr;    // memory address, I/O address in low 16 bits
    logic [7:0]  wrData;  // write byte
    logic        ioWr;    // I/O write strobe
    logic        ioRd;    // I/O read strobe
    logic        memCyc;  // memory cycle strobe
  } hdm_host_req_type;

  // one processor-side semaphore request
  typedef struct packed {
    logic [2:0] idx;      // semaphore number
    logic       wr;       // write strobe
    logic       rd;       // read strobe
    logic       data;     // 1 requests, 0 releases
  } hdm_dsp_sem_type;

endpackage : hdm_pkg

/* File: hw/hdm_semaphore.sv */
// semaphore cell: one test-and-set flag shared by host and processor
`timescale 1ns/10ps
module hdm_semaphore (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // host side
  input  wire logic hostWr,
  input  wire logic hostData,
  // processor side
  input  wire logic dspWr,
  input  wire logic dspData,
  input  wire logic dspClr,
  // ownership
  output logic      hostOwn,
  output logic      dspOwn
);
  import hdm_pkg::*;

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    logic hostOwn; // host holds the flag
    logic dspOwn;  // processor holds the flag
  } hdm_sem_state_type;

  hdm_sem_state_type state_r;   // registered state
  hdm_sem_state_type state_nxt; // next state

  // request, release and grant
  always_comb begin
    state_nxt = state_r;
    // host releases or requests; grant only if processor is free
    if (hostWr) begin
      if (!hostData) begin
        state_nxt.hostOwn = 1'b0;
      end else if (!state_r.dspOwn) begin
        state_nxt.hostOwn = 1'b1; // [R20]
      end
    end
    // processor releases or requests; host wins a same-cycle race
    if (dspWr) begin
      if (!dspData) begin
        state_nxt.dspOwn = 1'b0;
      end else if (!state_r.hostOwn && !(hostWr && hostData)) begin
        state_nxt.dspOwn = 1'b1; // [R20]
      end
    end
    // processor reset drops its claims
    if (dspClr) begin
      state_nxt.dspOwn = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign hostOwn = state_r.hostOwn;
  assign dspOwn  = state_r.dspOwn;

endmodule : hdm_semaphore

/* File: hw/hdm_dsp_decode.sv */
// processor address decode: boot map swap and expansion bank
`timescale 1ns/10ps
module hdm_dsp_decode (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // processor address and map bits
  input  wire logic [23:0] dspAddr,
  input  wire logic        bootMapSwap,
  input  wire logic        expSramBankSel,
  // decoded selects
  output logic             epromSel,
  output logic             priSramSel,
  output logic [13:0]      expSramAddr
);
  import hdm_pkg::*;

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    logic        epromSel;    // EPROM chosen
    logic        priSramSel;  // primary SRAM chosen
    logic [13:0] expSramAddr; // expansion SRAM word address
  } hdm_dec_state_type;

  hdm_dec_state_type state_r;   // registered state
  hdm_dec_state_type state_nxt; // next state
  logic              inLow;     // address in low boot range
  logic              inHigh;    // address in high range

  // range decode
  always_comb begin
    inLow  = (dspAddr >= HDM_LOW_BASE) && (dspAddr <= HDM_LOW_LAST);
    inHigh = (dspAddr >= HDM_HIGH_BASE) && (dspAddr <= HDM_HIGH_LAST);
    state_nxt = state_r;
    // swap exchanges which device answers each range
    state_nxt.epromSel   = bootMapSwap ? inHigh : inLow;  // [R16]
    state_nxt.priSramSel = bootMapSwap ? inLow : inHigh;  // [R16]
    // bank bit becomes the top word-address bit
    state_nxt.expSramAddr = {expSramBankSel, dspAddr[HDM_EXP_BANK_BITS-1:0]}; // [R15]
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign epromSel    = state_r.epromSel;
  assign priSramSel  = state_r.priSramSel;
  assign expSramAddr = state_r.expSramAddr;

endmodule : hdm_dsp_decode

/* File: hw/hdm_mailbox_ctrl.sv */
// host/processor mailbox control: window decode, control register, semaphores
`timescale 1ns/10ps
module hdm_mailbox_ctrl (
  // clock and resets
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 hostBusReset,
  input  wire logic                 dspReset,
  // host expansion bus
  input  wire hdm_pkg::hdm_host_req_type hostReq,
  output logic [7:0]                hostRdData,
  output logic                      hostShmSel,
  output logic [11:0]               hostShmAddr,
  output logic                      hostIrq,
  // processor control register port
  input  wire logic                 dspCtrlWr,
  input  wire logic [3:0]           dspCtrlWrData,
  output hdm_pkg::hdm_ctrl_type     dspCtrlRdData,
  // processor semaphore port
  input  wire hdm_pkg::hdm_dsp_sem_type dspSem,
  output logic                      dspSemRdData,
  // processor shared-memory data lanes
  input  wire logic [31:0]          dspShmWrWord,
  input  wire logic [7:0]           shmRdByte,
  output logic [7:0]                dspShmWrByte,
  output logic [31:0]               dspShmRdWord,
  // processor board controls
  output logic                      externalInterruptZero,
  output logic                      dspBoardReset,
  // processor address decode
  input  wire logic [23:0]          dspAddr,
  output logic                      epromSel,
  output logic                      priSramSel,
  output logic [13:0]               expSramAddr
);
  import hdm_pkg::*;

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    hdm_ctrl_type ctrl;         // shared control register
    logic [7:0]   windowBase;   // window base register
    logic [7:0]   hostRdData;   // host read byte
    logic         hostShmSel;   // host hits the shared window
    logic [11:0]  hostShmAddr;  // byte offset inside the window
    logic         hostIrq;      // interrupt toward the host
    logic         extInt0;      // interrupt toward the processor
    logic         boardReset;   // processor board held in reset
    logic         dspSemRd;     // processor semaphore read bit
    logic [7:0]   shmWrByte;    // processor write lane
    logic [31:0]  shmRdWord;    // processor read word
  } hdm_main_state_type;

  hdm_main_state_type state_r;   // registered state
  hdm_main_state_type state_nxt; // next state

  // ********************************************************************
  // host I/O decode
  // ********************************************************************
  logic [15:0] ioAddr;      // host I/O address
  logic        semHit;      // access lands on a semaphore
  logic [2:0]  semIdx;      // which semaphore the host addresses
  logic        baseHit;     // access lands on the window base
  logic        ctrlHit;     // access lands on the control register
  logic        winMatch;    // memory address falls in the window
  logic        dspNibClr;   // processor-owned nibble clear condition

  // semaphore wiring
  logic [HDM_SEM_COUNT-1:0] semHostWr; // host write per semaphore
  logic [HDM_SEM_COUNT-1:0] semDspWr;  // processor write per semaphore
  logic [HDM_SEM_COUNT-1:0] semHostOwn; // host ownership per semaphore
  logic [HDM_SEM_COUNT-1:0] semDspOwn;  // processor ownership per semaphore

  // address compares
  always_comb begin
    ioAddr   = hostReq.addr[15:0];
    semHit   = (ioAddr >= HDM_SEM_BASE_ADDR) && (ioAddr <= HDM_SEM_LAST_ADDR); // [R01]
    semIdx   = ioAddr[2:0];
    baseHit  = (ioAddr == HDM_WIN_BASE_ADDR); // [R02]
    ctrlHit  = (ioAddr == HDM_CTRL_ADDR);     // [R02]
    // 20-bit host address: 4K steps below 1M only
    winMatch = (hostReq.addr[HDM_WIN_MSB:HDM_WIN_LSB] == state_r.windowBase); // [R04] [R05]
    // soft reset low counts as a processor reset
    dspNibClr = dspReset || !state_r.ctrl.boardSoftReset;
  end

  // ********************************************************************
  // semaphores
  // ********************************************************************
  // one cell per semaphore; never gates memory
  genvar gi;
  generate
    for (gi = 0; gi < HDM_SEM_COUNT; gi++) begin : g_sem
      assign semHostWr[gi] = hostReq.ioWr && semHit && (semIdx == 3'(gi));
      assign semDspWr[gi]  = dspSem.wr && (dspSem.idx == 3'(gi));
      hdm_semaphore u_sem (
        .clk      (clk),
        .rst      (rst),
        .hostWr   (semHostWr[gi]),
        .hostData (hostReq.wrData[0]),
        .dspWr    (semDspWr[gi]),
        .dspData  (dspSem.data),
        .dspClr   (dspReset),
        .hostOwn  (semHostOwn[gi]),
        .dspOwn   (semDspOwn[gi])
      ); // [R17] [R20]
    end
  endgenerate

  // ********************************************************************
  // next-state logic
  // ********************************************************************
  // registers, read data, window decode and interrupt outputs
  always_comb begin
    state_nxt = state_r;

    // window base: host write only
    if (hostReq.ioWr && baseHit) begin
      state_nxt.windowBase = hostReq.wrData; // [R03]
    end

    // host owns bits 0..3; processor cannot touch them
    if (hostReq.ioWr && ctrlHit) begin
      state_nxt.ctrl.hostToDspIrq   = hostReq.wrData[HDM_BIT_H2D_IRQ];   // [R07] [R19]
      state_nxt.ctrl.hostIrqEnable  = hostReq.wrData[HDM_BIT_HIRQ_EN];   // [R07] [R19]
      state_nxt.ctrl.windowEnable   = hostReq.wrData[HDM_BIT_WIN_EN];    // [R07]
      state_nxt.ctrl.boardSoftReset = hostReq.wrData[HDM_BIT_SOFT_RST];  // [R07]
    end
    // host-issued reset clears the host nibble
    if (hostBusReset) begin
      {state_nxt.ctrl.boardSoftReset, state_nxt.ctrl.windowEnable,
       state_nxt.ctrl.hostIrqEnable, state_nxt.ctrl.hostToDspIrq} = HDM_NIBBLE_RST; // [R08]
    end

    // processor owns bits 4..7; host writes there are ignored
    if (dspCtrlWr) begin
      {state_nxt.ctrl.bootMapSwap, state_nxt.ctrl.expSramBankSel,
       state_nxt.ctrl.dspIrqEnable, state_nxt.ctrl.dspToHostIrq} = dspCtrlWrData; // [R07]
    end
    // any processor reset clears the processor nibble
    if (dspNibClr) begin
      {state_nxt.ctrl.bootMapSwap, state_nxt.ctrl.expSramBankSel,
       state_nxt.ctrl.dspIrqEnable, state_nxt.ctrl.dspToHostIrq} = HDM_NIBBLE_RST; // [R09]
    end

    // host read mux; base register and gaps read as a fixed value
    state_nxt.hostRdData = HDM_UNREAD_VALUE; // [R03]
    if (hostReq.ioRd) begin
      if (semHit) begin
        state_nxt.hostRdData = {7'h00, semHostOwn[semIdx]}; // [R01] [R20]
      end else if (ctrlHit) begin
        state_nxt.hostRdData = state_r.ctrl; // [R03]
      end
    end

    // shared window select; semaphores play no part here
    state_nxt.hostShmSel  = hostReq.memCyc && state_r.ctrl.windowEnable && winMatch; // [R04] [R06] [R17]
    state_nxt.hostShmAddr = hostReq.addr[HDM_WIN_LSB-1:0];

    // cross interrupts, each gated by its enable
    state_nxt.extInt0 = state_r.ctrl.hostToDspIrq && state_r.ctrl.dspIrqEnable; // [R10] [R11]
    state_nxt.hostIrq = state_r.ctrl.dspToHostIrq && state_r.ctrl.hostIrqEnable; // [R12] [R13]

    // board held in reset while the soft reset bit is low
    state_nxt.boardReset = !state_r.ctrl.boardSoftReset; // [R14]

    // processor semaphore read
    state_nxt.dspSemRd = semDspOwn[dspSem.idx]; // [R20]

    // byte lane only; upper lanes fixed on read
    state_nxt.shmWrByte = dspShmWrWord[HDM_SHM_BYTE_BITS-1:0];  // [R18]
    state_nxt.shmRdWord = {HDM_SHM_UPPER_FILL, shmRdByte};     // [R18]
  end

  // state register; power-on reset clears both nibbles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r            <= '0;
      state_r.windowBase <= HDM_WIN_BASE_RST;
      state_r.boardReset <= 1'b1; // [R14]
    end else begin
      state_r <= state_nxt;
    end
  end

  // ********************************************************************
  // processor address decode
  // ********************************************************************
  // swap and bank decode, registered
  hdm_dsp_decode u_dec (
    .clk            (clk),
    .rst            (rst),
    .dspAddr        (dspAddr),
    .bootMapSwap    (state_r.ctrl.bootMapSwap),
    .expSramBankSel (state_r.ctrl.expSramBankSel),
    .epromSel       (epromSel),
    .priSramSel     (priSramSel),
    .expSramAddr    (expSramAddr)
  ); // [R15] [R16]

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign hostRdData            = state_r.hostRdData;
  assign hostShmSel            = state_r.hostShmSel;
  assign hostShmAddr           = state_r.hostShmAddr;
  assign hostIrq               = state_r.hostIrq;
  assign dspCtrlRdData         = state_r.ctrl;
  assign dspSemRdData          = state_r.dspSemRd;
  assign dspShmWrByte          = state_r.shmWrByte;
  assign dspShmRdWord          = state_r.shmRdWord;
  assign externalInterruptZero = state_r.extInt0;
  assign dspBoardReset         = state_r.boardReset;

endmodule : hdm_mailbox_ctrl

/* File: verification/hdm_mailbox_sva.sv */
// checker: port-level assertions for the mailbox control block
`timescale 1ns/10ps
module hdm_mailbox_sva
  import hdm_pkg::*;
(
  // clock and resets
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  hostBusReset,
  input wire logic                  dspReset,
  // host side
  input wire hdm_pkg::hdm_host_req_type hostReq,
  input wire logic                  hostShmSel,
  input wire logic                  hostIrq,
  // processor side
  input wire logic                  dspCtrlWr,
  input wire logic [3:0]            dspCtrlWrData,
  input wire hdm_pkg::hdm_ctrl_type dspCtrlRdData,
  input wire logic [7:0]            shmRdByte,
  input wire logic [31:0]           dspShmRdWord,
  input wire logic                  externalInterruptZero,
  input wire logic                  dspBoardReset,
  input wire logic [23:0]           dspAddr,
  input wire logic                  epromSel,
  input wire logic                  priSramSel
);
  // ****************************************************************
  // helper: shadow of the write-only window base
  // ****************************************************************
  logic [7:0] baseShadow_r; // last base written by the host
  logic       ctrlWr;       // host write to the control register
  logic       baseHit;      // host address falls in the window
  assign ctrlWr  = hostReq.ioWr && hostReq.addr[15:0] == HDM_CTRL_ADDR;
  assign baseHit = hostReq.addr[19:12] == baseShadow_r;
  // base is write-only, so shadow it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baseShadow_r <= HDM_WIN_BASE_RST;
    end else if (hostReq.ioWr && hostReq.addr[15:0] == HDM_WIN_BASE_ADDR) begin
      baseShadow_r <= hostReq.wrData;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_win_hit: assert property (hostReq.memCyc && dspCtrlRdData.windowEnable && baseHit
    |=> hostShmSel) else $error("window hit not selected");
  a_win_miss: assert property (!(hostReq.memCyc && dspCtrlRdData.windowEnable && baseHit)
    |=> !hostShmSel) else $error("window selected without a hit");
  a_host_irq: assert property (1'b1 |=> hostIrq ==
    $past(dspCtrlRdData.dspToHostIrq && dspCtrlRdData.hostIrqEnable)) else $error("host irq");
  a_dsp_irq: assert property (1'b1 |=> externalInterruptZero ==
    $past(dspCtrlRdData.hostToDspIrq && dspCtrlRdData.dspIrqEnable)) else $error("dsp irq");
  a_board_hold: assert property (!dspCtrlRdData.boardSoftReset [*3] |-> dspBoardReset)
    else $error("board released while soft reset low");
  a_host_wr: assert property (ctrlWr && !hostBusReset
    |=> dspCtrlRdData[3:0] == $past(hostReq.wrData[3:0])) else $error("host nibble write");
  a_dsp_wr: assert property (dspCtrlWr && dspCtrlRdData.boardSoftReset && !dspReset
    && !hostBusReset && !hostReq.ioWr |=> dspCtrlRdData[7:4] == $past(dspCtrlWrData))
    else $error("processor nibble write");
  a_host_rst: assert property (hostBusReset |=> dspCtrlRdData[3:0] == HDM_NIBBLE_RST)
    else $error("host reset left low nibble");
  a_dsp_rst: assert property (dspReset |=> dspCtrlRdData[7:4] == HDM_NIBBLE_RST)
    else $error("processor reset left high nibble");
  a_shm_lanes: assert property (1'b1 |=> dspShmRdWord == {24'h000000, $past(shmRdByte)})
    else $error("shared memory read lanes");
  a_boot_map: assert property (dspAddr <= HDM_LOW_LAST || (dspAddr >= HDM_HIGH_BASE
    && dspAddr <= HDM_HIGH_LAST) |=> epromSel == ($past(dspAddr[23])
    == $past(dspCtrlRdData.bootMapSwap)) && priSramSel == !epromSel) else $error("boot map");
  // main scenarios reached
  c_win_hit: cover property (hostReq.memCyc ##1 hostShmSel);
  c_host_irq: cover property ($rose(hostIrq));
  c_swap: cover property (dspCtrlRdData.bootMapSwap && epromSel);
endmodule : hdm_mailbox_sva

bind hdm_mailbox_ctrl hdm_mailbox_sva u_sva (.*);

/* File: verification/hdm_host_model.sv */
// host model: drives host bus cycles as a host processor would
`timescale 1ns/10ps
module hdm_host_model (
  // clock
  input wire logic                 clk,
  // host bus
  output hdm_pkg::hdm_host_req_type hostReq,
  input wire logic [7:0]           hostRdData
);
  import hdm_pkg::*;
  // bus idle at time zero
  initial hostReq = '0;
  // set after an edge, held through the taking edge
  task automatic strobe(input logic [19:0] a, input logic [7:0] d, input logic wr,
                        input logic rd, input logic mem, output logic [7:0] q);
    @(posedge clk) #10 hostReq = '{addr: a, wrData: d, ioWr: wr, ioRd: rd, memCyc: mem};
    @(posedge clk) #10 q = hostRdData;
    // released lines show the inverse
    hostReq = '{addr: ~a, wrData: ~d, ioWr: 1'b0, ioRd: 1'b0, memCyc: 1'b0};
  endtask : strobe
endmodule : hdm_host_model

/* File: verification/hdm_mailbox_ctrl_bench.sv */
// bench: host and processor sequences against the mailbox control block
`timescale 1ns/10ps
module hdm_mailbox_ctrl_bench;
  import hdm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hostBusReset, dspReset, dspCtrlWr;
  logic [3:0] dspCtrlWrData;
  logic [31:0] dspShmWrWord, dspShmRdWord;
  logic [23:0] dspAddr;
  logic [7:0] shmRdByte, hostRdData, dspShmWrByte;
  logic [11:0] hostShmAddr;
  logic [13:0] expSramAddr;
  logic [15:0] semAddr;
  logic hostShmSel, hostIrq, dspSemRdData, externalInterruptZero, dspBoardReset;
  logic epromSel, priSramSel;
  hdm_host_req_type hostReq;
  hdm_dsp_sem_type dspSem;
  hdm_ctrl_type dspCtrlRdData;
  int errorCnt = 0, numChecks = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  hdm_host_model u_host (.clk(clk), .hostReq(hostReq), .hostRdData(hostRdData));
  hdm_mailbox_ctrl u_dut (.*);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    numChecks++;
    if (act !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.strobe({4'h0, a}, d, 1'b1, 1'b0, 1'b0, q);
  endtask : wr
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_host.strobe({4'h0, a}, 8'h00, 1'b0, 1'b1, 1'b0, q);
    chk(q, exp);
  endtask : rd_chk
  task automatic mem_chk(input logic [19:0] a, input logic exp);
    logic [7:0] q;
    u_host.strobe(a, 8'h00, 1'b0, 1'b0, 1'b1, q);
    chk(hostShmSel, exp);
    chk(hostShmAddr, a[11:0]);
  endtask : mem_chk
  task automatic dsp_ctrl(input logic [3:0] n);
    @(posedge clk) #10 {dspCtrlWr, dspCtrlWrData} = {1'b1, n};
    @(posedge clk) #10 {dspCtrlWr, dspCtrlWrData} = {1'b0, ~n};
    step(2);
  endtask : dsp_ctrl
  task automatic dsp_sem(input logic [2:0] i, input logic d);
    @(posedge clk) #10 dspSem = '{idx: i, wr: 1'b1, rd: 1'b0, data: d};
    @(posedge clk) #10 dspSem.wr = 1'b0;
    step(2);
  endtask : dsp_sem
  task automatic dec_chk(input logic [23:0] a, input logic ep, input logic ps, input logic bk);
    @(posedge clk) #10 dspAddr = a;
    step(1);
    chk(epromSel, ep);
    chk(priSramSel, ps);
    chk(expSramAddr, {bk, a[12:0]});
  endtask : dec_chk
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  task automatic finalReport();
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finalReport
  // ****************************************************************
  // watchdog and main sequence
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    finalReport();
  end
  initial begin
    {hostBusReset, dspReset, dspCtrlWr, dspCtrlWrData, dspSem} = '0;
    {dspShmWrWord, shmRdByte, dspAddr} = '0;
    step(20);
    rst = 1'b0;
    chk(dspBoardReset, 1'b1);
    rd_chk(HDM_CTRL_ADDR, 8'h00);
    rd_chk(HDM_WIN_BASE_ADDR, 8'h00);
    rd_chk(16'h033a, 8'h00);
    done("reset");
    // host releases board; upper nibble writes lost
    wr(HDM_CTRL_ADDR, 8'hf8);
    step(3);
    chk(dspBoardReset, 1'b0);
    rd_chk(HDM_CTRL_ADDR, 8'h08);
    dsp_ctrl(4'h2);
    chk(dspCtrlRdData, 8'h28);
    wr(HDM_CTRL_ADDR, 8'h09);
    step(2);
    chk(externalInterruptZero, 1'b1);
    dsp_ctrl(4'h0);
    chk(externalInterruptZero, 1'b0);
    dsp_ctrl(4'h2);
    chk(externalInterruptZero, 1'b1);
    wr(HDM_CTRL_ADDR, 8'h0a);
    dsp_ctrl(4'h3);
    chk(hostIrq, 1'b1);
    wr(HDM_CTRL_ADDR, 8'h08);
    step(2);
    chk(hostIrq, 1'b0);
    wr(HDM_CTRL_ADDR, 8'h0a);
    step(2);
    chk(hostIrq, 1'b1);
    done("control");
    wr(HDM_WIN_BASE_ADDR, 8'hd4);
    wr(HDM_CTRL_ADDR, 8'h0c);
    mem_chk(20'hd4123, 1'b1);
    mem_chk(20'hd5123, 1'b0);
    mem_chk(20'hd3fff, 1'b0);
    dsp_sem(3'd3, 1'b1);
    mem_chk(20'hd4000, 1'b1);
    dsp_sem(3'd3, 1'b0);
    wr(HDM_CTRL_ADDR, 8'h08);
    mem_chk(20'hd4000, 1'b0);
    done("window");
    for (int n = 0; n < HDM_SEM_COUNT; n++) begin
      semAddr = HDM_SEM_BASE_ADDR + 16'(n);
      wr(semAddr, 8'h01);
      rd_chk(semAddr, 8'h01);
      dsp_sem(3'(n), 1'b1);
      chk(dspSemRdData, 1'b0);
      wr(semAddr, 8'h00);
      dsp_sem(3'(n), 1'b1);
      chk(dspSemRdData, 1'b1);
      wr(semAddr, 8'h01);
      rd_chk(semAddr, 8'h00);
      dsp_sem(3'(n), 1'b0);
    end
    done("semaphores");
    for (int s = 0; s < 2; s++) begin
      dsp_ctrl({s[0], s[0], 2'b10});
      dec_chk(24'h000010, !s[0], s[0], s[0]);
      dec_chk(24'hf03fff, s[0], !s[0], s[0]);
      dec_chk(24'h004000, 1'b0, 1'b0, s[0]);
    end
    {shmRdByte, dspShmWrWord} = {8'h5a, 32'hdeadbe77};
    step(1);
    chk(dspShmRdWord, 32'h0000005a);
    chk(dspShmWrByte, 8'h77);
    done("processor map");
    @(posedge clk) #10 dspReset = 1'b1;
    @(posedge clk) #10 dspReset = 1'b0;
    chk(dspCtrlRdData, 8'h08);
    dsp_ctrl(4'hc);
    @(posedge clk) #10 hostBusReset = 1'b1;
    @(posedge clk) #10 hostBusReset = 1'b0;
    chk(dspCtrlRdData[3:0], 4'h0);
    step(3);
    chk(dspBoardReset, 1'b1);
    done("resets");
    finalReport();
  end
endmodule : hdm_mailbox_ctrl_bench
